// ---- hw/pwseq_regs.vh ----
// register map, field positions, reset values and timing counts of the write sequencer
`ifndef PWSEQ_REGS_VH
`define PWSEQ_REGS_VH

// byte offsets on the axi4-lite bus
`define PWSEQ_OFS_CTRL      4'h0
`define PWSEQ_OFS_ADDR      4'h4
`define PWSEQ_OFS_DATA      4'h8
`define PWSEQ_OFS_STAT      4'hC

// decoded register codes
`define PWSEQ_REG_CTRL      3'h0
`define PWSEQ_REG_ADDR      3'h1
`define PWSEQ_REG_DATA      3'h2
`define PWSEQ_REG_STAT      3'h3
`define PWSEQ_REG_NONE      3'h7

// port_control_register fields
`define PWSEQ_CTRL_EN       0
`define PWSEQ_CTRL_DUR_LO   1
`define PWSEQ_CTRL_DUR_HI   5
`define PWSEQ_CTRL_HOLD     6
`define PWSEQ_CTRL_FLASH    7
`define PWSEQ_CTRL_PACK_LO  8
`define PWSEQ_CTRL_PACK_HI  9
`define PWSEQ_CTRL_ALE_LOW  10
`define PWSEQ_CTRL_WIDTH    11
`define PWSEQ_CTRL_RESET    11'h000

// status fields
`define PWSEQ_STAT_BUSY     0
`define PWSEQ_STAT_PEND     1

`define PWSEQ_ADDR_RESET    16'h0000
`define PWSEQ_DATA_RESET    16'h0000

// timing, in peripheral clock cycles unless noted
`define PWSEQ_CORE_PER_PCLK 2
`define PWSEQ_ALE_PCLK      5'h02
`define PWSEQ_AHOLD_PCLK    5'h01
`define PWSEQ_DSETUP_PCLK   5'h01
`define PWSEQ_HOLD_PCLK     5'h01
`define PWSEQ_FLASH_PCLK    5'h07
`define PWSEQ_FLASH_MIN_DUR 5'h09

`define PWSEQ_RESP_OKAY     2'h0
`define PWSEQ_RESP_SLVERR   2'h2

`endif

// ---- hw/pwseq_pclk_tick.v ----
// peripheral clock enable generator: one tick every two core clocks
`include "pwseq_regs.vh"
`default_nettype none

module pwseq_pclk_tick (
	input  wire aclk,    // core clock
	input  wire aresetn, // synchronous reset, active low
	output wire tick     // one-cycle pulse per peripheral clock
);

	reg [1:0] div_ff;
	reg [1:0] nxt_div;

	always @* begin
		if (div_ff == (`PWSEQ_CORE_PER_PCLK - 1))
			nxt_div = 2'h0;
		else
			nxt_div = div_ff + 2'h1;
	end

	always @(posedge aclk) begin
		if (!aresetn)
			div_ff <= 2'h0;
		else
			div_ff <= nxt_div;
	end

	assign tick = (div_ff == (`PWSEQ_CORE_PER_PCLK - 1));

endmodule // pwseq_pclk_tick

`default_nettype wire

// ---- hw/pwseq_top.v ----
// parallel port write sequencer with axi4-lite register slave
// Function
// - intervals counted in two-core-clock peripheral cycles
// - address on bus before latch strobe ends
// - address held one cycle after strobe ends
// - write strobe two cycles after latch strobe
// - strobe low time is duration minus flash
// - data set up one cycle before strobe
// - data held hold interval after strobe rise
// - hold interval one cycle or zero
// - hold interval before next latch strobe
// - slow flash adds seven cycles, duration nine (not enforced: any shorter duration gives one cycle low)
// - packing nonzero: one strobe per latch cycle
// - packing zero: strobes spaced flash+hold+one
// - latch strobe active high after reset, programmable
`include "pwseq_regs.vh"
`default_nettype none

module pwseq_top (
	input  wire        aclk,      // core clock
	input  wire        aresetn,   // synchronous reset, active low
	input  wire [3:0]  awaddr,    // write address
	input  wire        awvalid,   // write address valid
	output wire        awready,   // write address ready
	input  wire [31:0] wdata,     // write data
	input  wire [3:0]  wstrb,     // write byte strobes
	input  wire        wvalid,    // write data valid
	output wire        wready,    // write data ready
	output wire [1:0]  bresp,     // write response
	output wire        bvalid,    // write response valid
	input  wire        bready,    // write response ready
	input  wire [3:0]  araddr,    // read address
	input  wire        arvalid,   // read address valid
	output wire        arready,   // read address ready
	output wire [31:0] rdata,     // read data
	output wire [1:0]  rresp,     // read response
	output wire        rvalid,    // read data valid
	input  wire        rready,    // read data ready
	output wire [15:0] ad_out,    // multiplexed_addr_data_bus drive value
	output wire        ad_oe,     // multiplexed_addr_data_bus output enable
	output wire        ale,       // address latch strobe pin
	output wire        wr_n       // write strobe, active low
);

	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_ALE   = 3'h1;
	localparam [2:0] ST_AHOLD = 3'h2;
	localparam [2:0] ST_DSET  = 3'h3;
	localparam [2:0] ST_WRLOW = 3'h4;
	localparam [2:0] ST_HOLD  = 3'h5;
	localparam [2:0] ST_GAP   = 3'h6;
	function [2:0] reg_sel;
		input [3:0] a;
		begin
			case (a)
				`PWSEQ_OFS_CTRL: reg_sel = `PWSEQ_REG_CTRL;
				`PWSEQ_OFS_ADDR: reg_sel = `PWSEQ_REG_ADDR;
				`PWSEQ_OFS_DATA: reg_sel = `PWSEQ_REG_DATA;
				`PWSEQ_OFS_STAT: reg_sel = `PWSEQ_REG_STAT;
				default:         reg_sel = `PWSEQ_REG_NONE;
			endcase
		end
	endfunction
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  be;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction
	wire        tick;
	reg                       aw_got_ff;
	reg                       w_got_ff;
	reg  [3:0]                awaddr_ff;
	reg  [31:0]               wdata_ff;
	reg  [3:0]                wstrb_ff;
	reg                       bvalid_ff;
	reg  [1:0]                bresp_ff;
	reg                       rvalid_ff;
	reg  [31:0]               rdata_ff;
	reg  [1:0]                rresp_ff;
	reg  [`PWSEQ_CTRL_WIDTH-1:0] ctrl_ff;
	reg  [15:0]               addr_ff;
	reg  [15:0]               data_ff;
	reg                       pend_ff;
	reg  [2:0]                state_ff;
	reg  [4:0]                cnt_ff;
	reg  [15:0]               bus_data_ff;
	reg  [15:0]               ad_out_ff;
	reg                       ad_oe_ff;
	reg                       ale_ff;
	reg                       wr_n_ff;

	reg  [2:0]                nxt_state;
	reg  [4:0]                nxt_cnt;
	reg                       pop;
	reg                       adv;
	reg  [15:0]               nxt_ad_out;
	reg                       nxt_ad_oe;
	reg                       nxt_ale_act;

	wire [2:0]  wsel;
	wire        wr_do;
	wire        wr_ctrl;
	wire        wr_addr;
	wire        wr_data;
	wire [31:0] wmerged;
	wire [31:0] ctrl_mrg;
	wire [31:0] addr_mrg;
	wire [15:0] nxt_addr;
	wire        en;
	wire [4:0]  dur;
	wire        hold_on;
	wire        flash_on;
	wire [1:0]  pack;
	wire        ale_low;
	wire [4:0]  flash_ext;
	wire [4:0]  wr_len;
	wire        more;
	wire        busy;
	reg  [31:0] rd_val;
	pwseq_pclk_tick u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (tick)
	);
	// axi4-lite write channel: address and data taken in either order
	assign awready = !aw_got_ff && !bvalid_ff;
	assign wready  = !w_got_ff && !bvalid_ff;
	assign wsel    = reg_sel(awaddr_ff);
	// a data write waits while the holding word is still full
	assign wr_do   = aw_got_ff && w_got_ff && !bvalid_ff &&
	                 !((wsel == `PWSEQ_REG_DATA) && pend_ff && !pop);
	assign wr_ctrl = wr_do && (wsel == `PWSEQ_REG_CTRL);
	assign wr_addr = wr_do && (wsel == `PWSEQ_REG_ADDR);
	assign wr_data = wr_do && (wsel == `PWSEQ_REG_DATA);
	assign wmerged = merge({16'h0000, data_ff}, wdata_ff, wstrb_ff);
	assign ctrl_mrg = merge({21'h000000, ctrl_ff}, wdata_ff, wstrb_ff);
	assign addr_mrg = merge({16'h0000, addr_ff}, wdata_ff, wstrb_ff);
	// software write of the address wins over the auto increment
	assign nxt_addr = wr_addr ? addr_mrg[15:0] : (adv ? addr_ff + 16'h0001 : addr_ff);
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			w_got_ff  <= 1'b0;
			awaddr_ff <= 4'h0;
			wdata_ff  <= 32'h00000000;
			wstrb_ff  <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= `PWSEQ_RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= awaddr;
			end
			if (wvalid && wready) begin
				w_got_ff <= 1'b1;
				wdata_ff <= wdata;
				wstrb_ff <= wstrb;
			end
			if (wr_do) begin
				aw_got_ff <= 1'b0;
				w_got_ff  <= 1'b0;
				bvalid_ff <= 1'b1;
				if (wsel == `PWSEQ_REG_NONE || wsel == `PWSEQ_REG_STAT)
					bresp_ff <= `PWSEQ_RESP_SLVERR;
				else
					bresp_ff <= `PWSEQ_RESP_OKAY;
			end else if (bvalid_ff && bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	assign bvalid = bvalid_ff;
	assign bresp  = bresp_ff;
	// register file
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= `PWSEQ_CTRL_RESET;
			addr_ff <= `PWSEQ_ADDR_RESET;
			data_ff <= `PWSEQ_DATA_RESET;
			pend_ff <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl_ff <= ctrl_mrg[`PWSEQ_CTRL_WIDTH-1:0];
			addr_ff <= nxt_addr;
			if (wr_data)
				data_ff <= wmerged[15:0];
			// a push in the cycle of the pop keeps the flag set
			pend_ff <= (pend_ff && !pop) || wr_data;
		end
	end
	assign en       = ctrl_ff[`PWSEQ_CTRL_EN];
	assign dur      = ctrl_ff[`PWSEQ_CTRL_DUR_HI:`PWSEQ_CTRL_DUR_LO];
	assign hold_on  = ctrl_ff[`PWSEQ_CTRL_HOLD];
	assign flash_on = ctrl_ff[`PWSEQ_CTRL_FLASH];
	assign pack     = ctrl_ff[`PWSEQ_CTRL_PACK_HI:`PWSEQ_CTRL_PACK_LO];
	assign ale_low  = ctrl_ff[`PWSEQ_CTRL_ALE_LOW];
	assign flash_ext = flash_on ? `PWSEQ_FLASH_PCLK : 5'h00;
	// durations not above the flash extension clamp to one cycle low
	assign wr_len   = (dur > flash_ext) ? (dur - flash_ext) : 5'h01;
	assign more     = en && pend_ff;
	assign busy     = (state_ff != ST_IDLE);
	// write cycle sequencer, advances only on peripheral clock ticks
	always @* begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		pop       = 1'b0;
		adv       = 1'b0;
		if (tick) begin
			if (cnt_ff != 5'h00) begin
				nxt_cnt = cnt_ff - 5'h01;
			end else begin
				case (state_ff)
					ST_IDLE: begin
						if (more) begin
							nxt_state = ST_ALE;
							nxt_cnt   = `PWSEQ_ALE_PCLK - 5'h01;
						end
					end
					ST_ALE: begin
						nxt_state = ST_AHOLD;
						nxt_cnt   = `PWSEQ_AHOLD_PCLK - 5'h01;
					end
					ST_AHOLD: begin
						nxt_state = ST_DSET;
						nxt_cnt   = `PWSEQ_DSETUP_PCLK - 5'h01;
						pop       = 1'b1;
					end
					ST_DSET: begin
						nxt_state = ST_WRLOW;
						nxt_cnt   = wr_len - 5'h01;
					end
					ST_WRLOW, ST_HOLD: begin
						if (state_ff == ST_WRLOW && hold_on) begin
							nxt_state = ST_HOLD;
							nxt_cnt   = `PWSEQ_HOLD_PCLK - 5'h01;
						end else begin
							adv = 1'b1;
							if (more && pack == 2'h0) begin
								if (flash_on) begin
									nxt_state = ST_GAP;
									nxt_cnt   = `PWSEQ_FLASH_PCLK - 5'h01;
								end else begin
									nxt_state = ST_DSET;
									nxt_cnt   = `PWSEQ_DSETUP_PCLK - 5'h01;
									pop       = 1'b1;
								end
							end else if (more) begin
								nxt_state = ST_ALE;
								nxt_cnt   = `PWSEQ_ALE_PCLK - 5'h01;
							end else begin
								nxt_state = ST_IDLE;
							end
						end
					end
					ST_GAP: begin
						nxt_state = ST_DSET;
						nxt_cnt   = `PWSEQ_DSETUP_PCLK - 5'h01;
						pop       = 1'b1;
					end
					default: begin
						nxt_state = ST_IDLE;
						nxt_cnt   = 5'h00;
					end
				endcase
			end
		end
	end
	// pin values for the coming state
	always @* begin
		nxt_ad_out  = bus_data_ff;
		nxt_ad_oe   = 1'b1;
		nxt_ale_act = 1'b0;
		case (nxt_state)
			ST_IDLE: begin
				nxt_ad_out = 16'h0000;
				nxt_ad_oe  = 1'b0;
			end
			ST_ALE: begin
				// new address from the first latch cycle, also after an increment
				nxt_ad_out  = nxt_addr;
				nxt_ale_act = 1'b1;
			end
			ST_AHOLD: begin
				nxt_ad_out = addr_ff;
			end
			ST_DSET: begin
				nxt_ad_out = pop ? data_ff : bus_data_ff;
			end
			default: begin
				nxt_ad_out = bus_data_ff;
			end
		endcase
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_ff    <= ST_IDLE;
			cnt_ff      <= 5'h00;
			bus_data_ff <= 16'h0000;
			ad_out_ff   <= 16'h0000;
			ad_oe_ff    <= 1'b0;
			ale_ff      <= 1'b0;
			wr_n_ff     <= 1'b1;
		end else begin
			state_ff  <= nxt_state;
			cnt_ff    <= nxt_cnt;
			if (pop)
				bus_data_ff <= data_ff;
			ad_out_ff <= nxt_ad_out;
			ad_oe_ff  <= nxt_ad_oe;
			ale_ff    <= nxt_ale_act ^ ale_low;
			wr_n_ff   <= (nxt_state != ST_WRLOW);
		end
	end

	assign ad_out = ad_out_ff;
	assign ad_oe  = ad_oe_ff;
	assign ale    = ale_ff;
	assign wr_n   = wr_n_ff;
	// axi4-lite read channel
	assign arready = !rvalid_ff;
	always @* begin
		case (reg_sel(araddr))
			`PWSEQ_REG_CTRL: rd_val = {21'h000000, ctrl_ff};
			`PWSEQ_REG_ADDR: rd_val = {16'h0000, addr_ff};
			`PWSEQ_REG_DATA: rd_val = {16'h0000, data_ff};
			`PWSEQ_REG_STAT: rd_val = {13'h0000, state_ff, 14'h0000, pend_ff, busy};
			default:         rd_val = 32'h00000000;
		endcase
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h00000000;
			rresp_ff  <= `PWSEQ_RESP_OKAY;
		end else begin
			if (arvalid && arready) begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= rd_val;
				if (reg_sel(araddr) == `PWSEQ_REG_NONE)
					rresp_ff <= `PWSEQ_RESP_SLVERR;
				else
					rresp_ff <= `PWSEQ_RESP_OKAY;
			end else if (rvalid_ff && rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	assign rvalid = rvalid_ff;
	assign rdata  = rdata_ff;
	assign rresp  = rresp_ff;
endmodule // pwseq_top

`default_nettype wire

// ---- bench/pwseq_monitor.sv ----
// pin checks of the write sequencer
`default_nettype none
module pwseq_monitor (
	input wire logic        aclk,    // clock
	input wire logic        aresetn, // reset
	input wire logic [15:0] ad_out,  // bus
	input wire logic        ad_oe,   // bus enable
	input wire logic        ale,     // latch strobe
	input wire logic        wr_n     // write strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] low_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn || wr_n) low_ff <= 8'h00;
		else low_ff <= low_ff + 8'h01;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rst; $rose(aresetn) |-> wr_n && !ad_oe && !ale; endproperty
	a_rst: assert property (p_rst) else $error("pins busy after reset");
	property p_oe; !wr_n |-> ad_oe; endproperty
	a_oe: assert property (p_oe) else $error("strobe on idle bus");
	property p_pace; $changed(wr_n) |=> $stable(wr_n); endproperty
	a_pace: assert property (p_pace) else $error("strobe off pclk grid");
	property p_even; $rose(wr_n) |-> low_ff >= 8'h02 && !low_ff[0]; endproperty
	a_even: assert property (p_even) else $error("bad strobe width");
	property p_dat; !wr_n && !$past(wr_n) |-> $stable(ad_out); endproperty
	a_dat: assert property (p_dat) else $error("data moved in strobe");
	property p_a2w; $fell(wr_n) |-> ale == $past(ale, 4); endproperty
	a_a2w: assert property (p_a2w) else $error("strobe too close to latch");
	property p_alew; $changed(ale) && ad_oe |=> $stable(ale) [*3]; endproperty
	a_alew: assert property (p_alew) else $error("latch strobe too short");
	property p_adh; $changed(ale) && ad_oe |=> $stable(ad_out); endproperty
	a_adh: assert property (p_adh) else $error("address not held");
endmodule // pwseq_monitor
bind pwseq_top pwseq_monitor mon_u (.aclk, .aresetn, .ad_out, .ad_oe, .ale, .wr_n);
`default_nettype wire

// ---- bench/pwseq_mem_model.sv ----
// address latch and memory on the bus, logging timing
`default_nettype none
module pwseq_mem_model (
	input wire logic        aclk,    // clock
	input wire logic        clr,     // empties logs
	input wire logic        ale_low, // latch polarity
	input wire logic [15:0] ad,      // bus
	input wire logic        ad_oe,   // bus enable
	input wire logic        ale,     // latch strobe
	input wire logic        wr_n     // write strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] addr_q[$], data_q[$], lat, prev, wd, lastd;
	int ale_q[$], a2w_q[$], low_q[$], set_q[$], post_q[$], sep_q[$], r2a_q[$];
	int act = 0, a2w = 0, low = 0, hi = 0, stab = 0, pc = -1, r2a = -1, lasts = 0;
	logic was_wr = 1'b1, fresh = 1'b0;
	always @(posedge aclk) begin
		a2w++;
		hi++;
		stab = ad === prev ? stab + 1 : 0;
		prev = ad;
		if (r2a >= 0) r2a++;
		if (!wr_n) begin
			lastd = ad;
			lasts = stab + 1;
		end
		// memory takes the word standing at the last sample before the rise
		if (wr_n && !was_wr) begin
			addr_q.push_back(lat);
			data_q.push_back(lastd);
			low_q.push_back(low);
			set_q.push_back(lasts);
			wd = lastd;
			pc = 0;
			hi = 0;
			r2a = 0;
		end
		if (pc >= 0 && (ad !== wd || !ad_oe || pc == 2)) begin
			post_q.push_back(pc);
			pc = -1;
		end else if (pc >= 0) pc++;
		if ((ale ^ ale_low) && ad_oe) begin
			if (act == 0 && r2a >= 0) r2a_q.push_back(r2a);
			r2a = -1;
			act++;
		end else if (act > 0) begin
			lat = ad;
			ale_q.push_back(act);
			act = 0;
			a2w = 0;
			fresh = 1'b1;
		end
		if (!wr_n && was_wr) begin
			if (fresh) a2w_q.push_back(a2w);
			else sep_q.push_back(hi);
			fresh = 1'b0;
			low = 0;
		end
		if (!wr_n) low++;
		was_wr = wr_n;
		if (clr) begin
			addr_q = {};
			data_q = {};
			ale_q = {};
			a2w_q = {};
			low_q = {};
			set_q = {};
			post_q = {};
			sep_q = {};
			r2a_q = {};
			r2a = -1;
		end
	end
endmodule // pwseq_mem_model
`default_nettype wire

// ---- bench/test_parallel_port_write_sequencer.sv ----
// self-checking bench of the write sequencer
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
	$display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module test_parallel_port_write_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, ale_low = 1'b0, clr = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, ad_oe, ale, wr_n;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h00000000, rdata, d, seed = 32'h0000993C;
	logic [1:0]  bresp, rresp, r;
	logic [15:0] ad_out, a0, w[2];
	int          num_errors = 0, samples_checked = 0, i, k, du, f, ho, lw;
	always #20 aclk = ~aclk;
	pwseq_top dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .ad_out, .ad_oe, .ale, .wr_n);
	pwseq_mem_model mdl_u (.aclk, .clr, .ale_low, .ad(ad_out), .ad_oe, .ale, .wr_n);
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] s);
		logic ta, tw, tb;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			s = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end
		@(posedge aclk);
	endtask
	task automatic axr(input logic [3:0] a, output logic [31:0] q, output logic [1:0] s);
		logic ta, tr;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			q = rdata;
			s = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end
		@(posedge aclk);
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		conclude();
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		`CHK({ale, wr_n, ad_oe}, 3'b010)
		@(posedge aclk);
		for (i = 0; i < 4; i++) begin
			axr(4'(i * 4), d, r);
			`CHK({r, d}, 34'h000000000)
		end
		axr(4'h6, d, r);
		`CHK({r, d}, 34'h200000000)
		axw(4'hC, 32'h00000001, r);
		`CHK(r, 2'h2)
		for (k = 0; k < 16; k++) begin
			f = k[0] ? 7 : 0;
			ho = k[1];
			du = k < 2 ? 1 + 8 * k : (k == 2 ? 31 : f + 2 + rnd() % (30 - f));
			d = rnd();
			ale_low = d[0];
			a0 = d[31:16];
			w[0] = d[15:0];
			d = rnd();
			w[1] = d[15:0];
			clr <= 1'b1;
			axw(4'h0, {21'h0, ale_low, k[3:2], k[0], k[1], du[4:0], 1'b1}, r);
			clr <= 1'b0;
			axw(4'h4, {16'h0000, a0}, r);
			axw(4'h8, {16'h0000, w[0]}, r);
			axw(4'h8, {16'h0000, w[1]}, r);
			i = 0;
			do begin
				axr(4'hC, d, r);
				i++;
			end while (d[1:0] !== 2'h0 && i < 300);
			`CHK(d[1:0], 2'h0)
			axr(4'h4, d, r);
			`CHK(d[15:0], a0 + 16'h0002)
			lw = 2 * (du > f ? du - f : 1);
			`CHK(ale, ale_low)
			`CHK(mdl_u.ale_q.size(), k[3:2] ? 2 : 1)
			`CHK(mdl_u.ale_q[0], 4)
			`CHK(mdl_u.addr_q[0], a0)
			`CHK(mdl_u.a2w_q[0], 4)
			for (i = 0; i < 2; i++) begin
				`CHK(mdl_u.data_q[i], w[i])
				`CHK(mdl_u.low_q[i], lw)
				`CHK(mdl_u.set_q[i], lw + 2)
				`CHK(mdl_u.post_q[i], (ho || (f != 0 && i == 0 && k[3:2] == 0)) ? 2 : 0)
			end
			if (k[3:2]) begin
				`CHK(mdl_u.addr_q[1], a0 + 16'h0001)
				`CHK(mdl_u.r2a_q[0], 2 * ho)
			end else `CHK(mdl_u.sep_q[0], 2 * (f + ho + 1))
		end
		conclude();
	end
endmodule // test_parallel_port_write_sequencer
`default_nettype wire
